// *** verilog/press_cfg_pkg.sv ***
// shared constants of the pressure sensor configuration registers
package press_cfg_pkg;
    // 7-bit register addresses
    localparam logic [6:0] ADDR_REF_LOW    = 7'h08;
    localparam logic [6:0] ADDR_REF_MID    = 7'h09;
    localparam logic [6:0] ADDR_REF_HIGH   = 7'h0A;
    localparam logic [6:0] ADDR_IDENTITY   = 7'h0F;
    localparam logic [6:0] ADDR_AVG_CFG    = 7'h10;
    localparam logic [6:0] ADDR_MAIN_CTRL  = 7'h20;
    localparam logic [6:0] ADDR_SEC_CTRL   = 7'h21;
    localparam logic [6:0] ADDR_STATUS     = 7'h27;
    localparam logic [6:0] ADDR_PRESS_LOW  = 7'h28;
    localparam logic [6:0] ADDR_PRESS_MID  = 7'h29;
    localparam logic [6:0] ADDR_PRESS_HIGH = 7'h2A;
    localparam logic [6:0] ADDR_TEMP_LOW   = 7'h2B;
    localparam logic [6:0] ADDR_TEMP_HIGH  = 7'h2C;
    localparam logic [6:0] ADDR_OFS_LOW    = 7'h39;
    localparam logic [6:0] ADDR_OFS_HIGH   = 7'h3A;

    // reset values
    localparam logic [7:0] AVG_CFG_RST   = 8'h0F;
    localparam logic [7:0] MAIN_CTRL_RST = 8'h00;
    localparam logic [7:0] OFS_RST       = 8'h00;

    // main control field positions
    localparam int MC_ACTIVE   = 7;
    localparam int MC_RATE_LSB = 4;
    localparam int MC_DIFF     = 3;
    localparam int MC_BLOCK    = 2;
    localparam int MC_AZ_CLR   = 1;
    localparam int MC_WIRE     = 0;
    // secondary control field positions
    localparam int SC_AZ_EN    = 1;
    localparam int SC_TRIGGER  = 0;
    // status field positions
    localparam int ST_TEMP     = 0;
    localparam int ST_PRESS    = 1;

    // rate codes
    localparam logic [2:0] RATE_SINGLE = 3'h0;
    localparam logic [2:0] RATE_1HZ    = 3'h1;
    localparam logic [2:0] RATE_7HZ    = 3'h2;
    localparam logic [2:0] RATE_12HZ   = 3'h3;
    localparam logic [2:0] RATE_25HZ   = 3'h4;

    // update rates in centihertz and their periods in core_clk cycles
    localparam longint CLK_HZ      = 20_000_000;
    localparam longint RATE_1_CHZ  = 100;
    localparam longint RATE_7_CHZ  = 700;
    localparam longint RATE_12_CHZ = 1250;
    localparam longint RATE_25_CHZ = 2500;
    localparam int PERIOD_1_CYC  = int'(CLK_HZ * 100 / RATE_1_CHZ);
    localparam int PERIOD_7_CYC  = int'(CLK_HZ * 100 / RATE_7_CHZ);
    localparam int PERIOD_12_CYC = int'(CLK_HZ * 100 / RATE_12_CHZ);
    localparam int PERIOD_25_CYC = int'(CLK_HZ * 100 / RATE_25_CHZ);

    typedef enum logic [1:0] {
        CONV_IDLE = 2'b01,
        CONV_BUSY = 2'b10
    } conv_state_t;
endpackage

// *** verilog/pressure_sensor_config_regs.sv ***
// configuration, reference and output registers of the pressure sensor
// Summary of operation
// RL1: registers selected by seven bit address
// RL2: signed 24-bit reference over three bytes
// RL3: measured minus reference feeds limits, autozero
// RL4: temperature averaging 8..64, reset code 11
// RL5: pressure averaging 8..512, reset code 11
// RL6: power bit zero holds power-down
// RL7: rate codes 1..4 give periodic updates
// RL8: rate zero: each trigger one conversion
// RL9: differential enable gates differential output
// RL10: host writes reference before enabling differential
// RL11: block-update zero: outputs follow samples
// RL12: block-update one: freeze until both read
// RL13: autozero clear wipes reference, offsets; self-clears
// RL14: wire select picks four or three wire
// RL15: autozero enable copies pressure into reference
// RL16: single conversion done clears trigger, updates
// RL17: reserved averaging bits read zero, ignored
module pressure_sensor_config_regs
    import press_cfg_pkg::*;
#(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A, // arbitrary value
    parameter int         PERIOD_1HZ    = PERIOD_1_CYC,
    parameter int         PERIOD_7HZ    = PERIOD_7_CYC,
    parameter int         PERIOD_12HZ   = PERIOD_12_CYC,
    parameter int         PERIOD_25HZ   = PERIOD_25_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [6:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [23:0] press_sample,
    input  wire logic [15:0] temp_sample,
    output logic      [6:0]  temp_avg_samples,
    output logic      [9:0]  press_avg_samples,
    output logic             device_active,
    output logic             three_wire_mode,
    output logic             diff_enabled,
    output logic      [23:0] diff_pressure,
    output logic      [15:0] press_offset
);

    // refused at elaboration: the rate counter needs two cycles or more
    if (PERIOD_1HZ < 2 || PERIOD_7HZ < 2 || PERIOD_12HZ < 2 ||
        PERIOD_25HZ < 2) begin : g_bad_period
        $error("rate periods must be at least two cycles");
    end

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [23:0] ref_q;
    logic [3:0]  avg_q;
    logic [7:0]  main_q;
    logic        az_en_q;
    logic        trig_q;
    logic [1:0]  stat_q;
    logic [15:0] ofs_q;
    logic [23:0] press_new_q;
    logic [15:0] temp_new_q;
    logic [23:0] press_out_q;
    logic [15:0] temp_out_q;
    logic        p_lock_q;
    logic        p_lo_rd_q;
    logic        p_hi_rd_q;
    logic        t_lock_q;
    logic        t_lo_rd_q;
    logic        t_hi_rd_q;
    logic [31:0] rate_cnt_q;
    logic        pend_q;
    conv_state_t conv_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    // RL1: seven bit decode
    wire wr_ref_lo  = reg_wr && reg_addr == ADDR_REF_LOW;
    wire wr_ref_mid = reg_wr && reg_addr == ADDR_REF_MID;
    wire wr_ref_hi  = reg_wr && reg_addr == ADDR_REF_HIGH;
    wire wr_avg     = reg_wr && reg_addr == ADDR_AVG_CFG;
    wire wr_main    = reg_wr && reg_addr == ADDR_MAIN_CTRL;
    wire wr_sec     = reg_wr && reg_addr == ADDR_SEC_CTRL;
    wire wr_ofs_lo  = reg_wr && reg_addr == ADDR_OFS_LOW;
    wire wr_ofs_hi  = reg_wr && reg_addr == ADDR_OFS_HIGH;
    wire rd_p_lo    = reg_rd && reg_addr == ADDR_PRESS_LOW;
    wire rd_p_mid   = reg_rd && reg_addr == ADDR_PRESS_MID;
    wire rd_p_hi    = reg_rd && reg_addr == ADDR_PRESS_HIGH;
    wire rd_t_lo    = reg_rd && reg_addr == ADDR_TEMP_LOW;
    wire rd_t_hi    = reg_rd && reg_addr == ADDR_TEMP_HIGH;

    wire        active    = main_q[MC_ACTIVE];
    wire [2:0]  rate      = main_q[MC_RATE_LSB+:3];
    wire        differential_enable   = main_q[MC_DIFF];
    wire        block_upd = main_q[MC_BLOCK];
    // RL13: clear strobe, never stored
    wire        az_clear  = wr_main && reg_wdata[MC_AZ_CLR];
    // RL15: copy on enabling autozero
    wire        az_rise   = wr_sec && reg_wdata[SC_AZ_EN] && !az_en_q;

    ////////////////////////////////////////////////////////////////////////
    // conversion scheduling
    logic [31:0] period;
    always_comb begin
        case (rate)
            RATE_1HZ:  period = 32'(PERIOD_1HZ);
            RATE_7HZ:  period = 32'(PERIOD_7HZ);
            RATE_12HZ: period = 32'(PERIOD_12HZ);
            RATE_25HZ: period = 32'(PERIOD_25HZ);
            default:   period = 32'h0;
        endcase
    end

    // RL7: reserved codes give period zero
    wire periodic = active && period != 32'h0;
    wire tick     = periodic && rate_cnt_q >= period - 32'h1;
    // RL8: single mode waits on trigger
    wire single   = active && rate == RATE_SINGLE;
    wire request  = tick || pend_q || (single && trig_q);
    // RL6: nothing starts in power-down
    wire start    = active && conv_q == CONV_IDLE && request;
    wire done     = conv_q == CONV_BUSY && conv_done;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_cnt_q <= 32'h0;
        end else if (!periodic || tick) begin
            rate_cnt_q <= 32'h0;
        end else begin
            rate_cnt_q <= rate_cnt_q + 32'h1;
        end
    end

    // a tick during a running conversion is kept, not lost
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
        end else if (!periodic) begin
            pend_q <= 1'b0;
        end else if (tick && conv_q == CONV_BUSY) begin
            pend_q <= 1'b1;
        end else if (start) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_q <= CONV_IDLE;
        end else begin
            case (conv_q)
                CONV_IDLE: begin
                    if (start) begin
                        conv_q <= CONV_BUSY;
                    end
                end
                CONV_BUSY: begin
                    if (conv_done) begin
                        conv_q <= CONV_IDLE;
                    end
                end
                default: conv_q <= CONV_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_q <= 24'h0;
        end else if (az_clear) begin
            // RL13: reference wiped
            ref_q <= 24'h0;
        end else if (az_rise) begin
            // RL15: capture newest pressure
            ref_q <= press_new_q;
        end else begin
            // RL2: byte lanes of the reference
            if (wr_ref_lo) ref_q[7:0]   <= reg_wdata;
            if (wr_ref_mid) ref_q[15:8] <= reg_wdata;
            if (wr_ref_hi) ref_q[23:16] <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avg_q <= AVG_CFG_RST[3:0];
            main_q <= MAIN_CTRL_RST;
            ofs_q <= {OFS_RST, OFS_RST};
            az_en_q <= 1'b0;
        end else begin
            // RL17: upper bits dropped
            if (wr_avg) avg_q <= reg_wdata[3:0];
            // RL13: clear bit not kept
            if (wr_main) main_q <= reg_wdata & ~(8'h01 << MC_AZ_CLR);
            if (wr_sec) az_en_q <= reg_wdata[SC_AZ_EN];
            if (az_clear) begin
                // RL13: offsets back to default
                ofs_q <= {OFS_RST, OFS_RST};
            end else begin
                if (wr_ofs_lo) ofs_q[7:0] <= reg_wdata;
                if (wr_ofs_hi) ofs_q[15:8] <= reg_wdata;
            end
        end
    end

    // set by host wins over the clear at completion
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trig_q <= 1'b0;
        end else if (wr_sec) begin
            trig_q <= reg_wdata[SC_TRIGGER];
        end else if (done && trig_q) begin
            // RL16: trigger self-clears
            trig_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // samples and output registers
    // RL3: measured minus reference
    wire [23:0] diff_val  = press_sample - ref_q;
    // RL15: subtract while autozero runs
    wire [23:0] press_val = (differential_enable || az_en_q) ? diff_val : press_sample;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            press_new_q <= 24'h0;
            temp_new_q <= 16'h0;
            diff_pressure <= 24'h0;
        end else if (done) begin
            press_new_q <= press_val;
            temp_new_q <= temp_sample;
            // RL9: differential only when enabled
            if (differential_enable) diff_pressure <= diff_val;
        end
    end

    // set by a fresh sample beats the clear by a read
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stat_q <= 2'b00;
        end else begin
            // RL16: status follows new data
            stat_q[ST_PRESS] <= done || (stat_q[ST_PRESS] && !rd_p_hi);
            stat_q[ST_TEMP] <= done || (stat_q[ST_TEMP] && !rd_t_hi);
        end
    end

    // RL12: lock opens once low and high both read
    wire p_both = (p_lo_rd_q || rd_p_lo) && (p_hi_rd_q || rd_p_hi);
    wire t_both = (t_lo_rd_q || rd_t_lo) && (t_hi_rd_q || rd_t_hi);
    wire p_rd   = rd_p_lo || rd_p_mid || rd_p_hi;
    wire t_rd   = rd_t_lo || rd_t_hi;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            p_lock_q <= 1'b0;
            p_lo_rd_q <= 1'b0;
            p_hi_rd_q <= 1'b0;
        end else if (!block_upd || (p_lock_q && p_both)) begin
            p_lock_q <= 1'b0;
            p_lo_rd_q <= 1'b0;
            p_hi_rd_q <= 1'b0;
        end else if (p_rd) begin
            // RL12: freeze on first read
            p_lock_q <= 1'b1;
            p_lo_rd_q <= p_lo_rd_q || rd_p_lo;
            p_hi_rd_q <= p_hi_rd_q || rd_p_hi;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            t_lock_q <= 1'b0;
            t_lo_rd_q <= 1'b0;
            t_hi_rd_q <= 1'b0;
        end else if (!block_upd || (t_lock_q && t_both)) begin
            t_lock_q <= 1'b0;
            t_lo_rd_q <= 1'b0;
            t_hi_rd_q <= 1'b0;
        end else if (t_rd) begin
            t_lock_q <= 1'b1;
            t_lo_rd_q <= t_lo_rd_q || rd_t_lo;
            t_hi_rd_q <= t_hi_rd_q || rd_t_hi;
        end
    end

    // RL11: unlocked outputs follow the newest sample
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            press_out_q <= 24'h0;
            temp_out_q <= 16'h0;
        end else begin
            if (!p_lock_q) press_out_q <= press_new_q;
            if (!t_lock_q) temp_out_q <= temp_new_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    logic [7:0] rd_mux;
    always_comb begin
        case (reg_addr)
            ADDR_REF_LOW:    rd_mux = ref_q[7:0];
            ADDR_REF_MID:    rd_mux = ref_q[15:8];
            ADDR_REF_HIGH:   rd_mux = ref_q[23:16];
            ADDR_IDENTITY:   rd_mux = IDENTITY_CODE;
            // RL17: reserved bits read zero
            ADDR_AVG_CFG:    rd_mux = {4'h0, avg_q};
            ADDR_MAIN_CTRL:  rd_mux = main_q;
            ADDR_SEC_CTRL:   rd_mux = {6'h00, az_en_q, trig_q};
            ADDR_STATUS:     rd_mux = {6'h00, stat_q};
            // a locked read sees the held value, an unlocked read the newest sample
            ADDR_PRESS_LOW:  rd_mux = p_lock_q ? press_out_q[7:0]
                                               : press_new_q[7:0];
            ADDR_PRESS_MID:  rd_mux = p_lock_q ? press_out_q[15:8]
                                               : press_new_q[15:8];
            ADDR_PRESS_HIGH: rd_mux = p_lock_q ? press_out_q[23:16]
                                               : press_new_q[23:16];
            ADDR_TEMP_LOW:   rd_mux = t_lock_q ? temp_out_q[7:0]
                                               : temp_new_q[7:0];
            ADDR_TEMP_HIGH:  rd_mux = t_lock_q ? temp_out_q[15:8]
                                               : temp_new_q[15:8];
            ADDR_OFS_LOW:    rd_mux = ofs_q[7:0];
            ADDR_OFS_HIGH:   rd_mux = ofs_q[15:8];
            default:         rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) reg_rdata <= rd_mux;
            conv_start <= start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration outputs
    // RL4: temperature sample count
    assign temp_avg_samples  = 7'h08 << avg_q[3:2];
    // RL5: pressure sample count
    assign press_avg_samples = 10'h008 << {avg_q[1:0], 1'b0};
    assign device_active     = active;
    // RL14: wire count to serial engine
    assign three_wire_mode   = main_q[MC_WIRE];
    // RL9: enable for threshold logic, RL10 up to the host
    assign diff_enabled      = differential_enable;
    assign press_offset      = ofs_q;

endmodule

// *** tb/press_cfg_checker.sv ***
// port assertions of the configuration register block
module press_cfg_checker
    import press_cfg_pkg::*;
#(
    parameter logic [7:0] IDENTITY_CODE = 8'h5A // arbitrary value
) (
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire logic [6:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        conv_start,
    input wire logic [6:0]  temp_avg_samples,
    input wire logic [9:0]  press_avg_samples,
    input wire logic        device_active,
    input wire logic        three_wire_mode,
    input wire logic        diff_enabled,
    input wire logic [15:0] press_offset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic ctrl_wr = reg_wr && reg_addr == ADDR_MAIN_CTRL;
    wire logic avg_wr  = reg_wr && reg_addr == ADDR_AVG_CFG;
    ////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    a_identity_value: assert property
        (reg_rd && reg_addr == ADDR_IDENTITY |=> reg_rdata == IDENTITY_CODE)
        else $error("identity value wrong");
    a_temp_avg_code: assert property (avg_wr |=>
        temp_avg_samples == 7'(8 << $past(reg_wdata[3:2])))
        else $error("temperature averaging wrong");
    a_press_avg_code: assert property (avg_wr |=>
        press_avg_samples == 10'(8 << {$past(reg_wdata[1:0]), 1'b0}))
        else $error("pressure averaging wrong");
    a_ctrl_bits_follow: assert property (ctrl_wr |=>
        {device_active, diff_enabled, three_wire_mode} == {$past(reg_wdata[7]),
        $past(reg_wdata[3]), $past(reg_wdata[0])})
        else $error("control bits wrong");
    // a start launched in power-down would burn converter power
    a_idle_no_start: assert property (!device_active |=> !conv_start)
        else $error("start while powered down");
    a_offset_clear: assert property
        (ctrl_wr && reg_wdata[MC_AZ_CLR] |=> press_offset == 16'h0000)
        else $error("offset not cleared");
    a_start_single: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
endmodule
////////////////////////////////////////////////////////////////////////////
bind pressure_sensor_config_regs press_cfg_checker #(
    .IDENTITY_CODE(IDENTITY_CODE)
) chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_start(conv_start),
    .temp_avg_samples(temp_avg_samples),
    .press_avg_samples(press_avg_samples), .device_active(device_active),
    .three_wire_mode(three_wire_mode), .diff_enabled(diff_enabled),
    .press_offset(press_offset)
);

// *** tb/conv_model.sv ***
// converter model answering each start after a fixed delay
module conv_model #(
    parameter int LATENCY = 3
) (
    input  wire logic        core_clk,
    input  wire logic        conv_start,
    input  wire logic [23:0] press_val,
    output logic             conv_done,
    output logic      [23:0] press_sample,
    output logic      [15:0] temp_sample
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        conv_done = 1'b0;
        press_sample = 24'h000000;
        temp_sample = 16'h0000;
        forever begin
            @(posedge core_clk) #1;
            if (conv_start === 1'b1) begin
                repeat (LATENCY) @(posedge core_clk);
                #1 conv_done = 1'b1;
                press_sample = press_val;
                temp_sample = press_val[15:0];
                @(posedge core_clk) #1;
                conv_done = 1'b0;
                // samples mean nothing without done, so show other bits
                press_sample = ~press_val;
                temp_sample = ~press_val[15:0];
            end
        end
    end
endmodule

// *** tb/test_pressure_sensor_config_regs.sv ***
// self-checking bench of the configuration register block
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin \
    miscompares++; $display("unexpected at %0t: %s", $time, m); end end
module test_pressure_sensor_config_regs
    import press_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] ID = 8'hA6; // arbitrary value
    // short periods keep the run small; expectations use the same table
    localparam int PER [1:4] = '{40, 30, 20, 10};
    logic        core_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [6:0]  reg_addr = 7'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [23:0] press_val = 24'h000000;
    logic [7:0]  reg_rdata;
    logic        reg_rvalid, conv_start, conv_done;
    logic [23:0] press_sample, diff_pressure;
    logic [15:0] temp_sample, press_offset;
    logic [6:0]  temp_avg_samples;
    logic [9:0]  press_avg_samples;
    logic        device_active, three_wire_mode, diff_enabled;
    int          miscompares = 0;
    int          checked = 0;
    int          n;
    ////////////////////////////////////////////////////////////////////////
    pressure_sensor_config_regs #(
        .IDENTITY_CODE(ID), .PERIOD_1HZ(PER[1]), .PERIOD_7HZ(PER[2]),
        .PERIOD_12HZ(PER[3]), .PERIOD_25HZ(PER[4])
    ) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .conv_start(conv_start), .conv_done(conv_done),
        .press_sample(press_sample), .temp_sample(temp_sample),
        .temp_avg_samples(temp_avg_samples),
        .press_avg_samples(press_avg_samples), .device_active(device_active),
        .three_wire_mode(three_wire_mode), .diff_enabled(diff_enabled),
        .diff_pressure(diff_pressure), .press_offset(press_offset)
    );
    conv_model conv (
        .core_clk(core_clk), .conv_start(conv_start), .press_val(press_val),
        .conv_done(conv_done), .press_sample(press_sample),
        .temp_sample(temp_sample)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        @(posedge core_clk) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        `CHK(reg_rvalid, 1'b1, "read not answered")
        `CHK(reg_rdata, e, "read data")
    endtask
    task automatic rd24(input logic [6:0] a, input logic [23:0] e);
        rd(a, e[7:0]);
        rd(a + 7'h01, e[15:8]);
        rd(a + 7'h02, e[23:16]);
    endtask
    task automatic wait_ev(input bit done, input int lim);
        n = 0;
        // look after the partner's 1 ns update so done is never raced
        do begin
            @(posedge core_clk) #2;
            n++;
        end while (n < lim && (done ? conv_done : conv_start) !== 1'b1);
    endtask
    task automatic shot();
        wait_ev(1'b0, 100);
        wait_ev(1'b1, 100);
        repeat (2) @(posedge core_clk);
    endtask
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial forever #25 core_clk = ~core_clk;
    // the tests need under 2000 cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        #1 sys_rst = 1'b0;
        rd(ADDR_AVG_CFG, 8'h0F);
        `CHK(temp_avg_samples, 7'h40, "temp avg reset")
        `CHK(press_avg_samples, 10'h200, "press avg reset")
        rd(ADDR_MAIN_CTRL, 8'h00);
        wr(ADDR_IDENTITY, 8'h00);
        rd(ADDR_IDENTITY, ID);
        rd(7'h05, 8'h00);
        wr(ADDR_MAIN_CTRL, 8'h01);
        `CHK(three_wire_mode, 1'b1, "wire select")
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_AVG_CFG, {4'hF, 2'(c), 2'(c)});
            `CHK(temp_avg_samples, 7'(8 << c), "temp avg")
            `CHK(press_avg_samples, 10'(8 << (2 * c)), "press avg")
            rd(ADDR_AVG_CFG, {4'h0, 2'(c), 2'(c)});
        end
        $display("test config finished");
        press_val = 24'h012345;
        // reference written before the difference is enabled
        wr(ADDR_REF_LOW, 8'h56);
        wr(ADDR_REF_MID, 8'h34);
        wr(ADDR_REF_HIGH, 8'hF2);
        rd24(ADDR_REF_LOW, 24'hF23456);
        wr(ADDR_MAIN_CTRL, 8'h88);
        wr(ADDR_SEC_CTRL, 8'h01);
        shot();
        `CHK(diff_pressure, 24'h012345 - 24'hF23456, "difference")
        rd(ADDR_SEC_CTRL, 8'h00);
        rd(ADDR_STATUS, 8'h03);
        rd24(ADDR_PRESS_LOW, 24'h012345 - 24'hF23456);
        wr(ADDR_MAIN_CTRL, 8'hD0);
        wait_ev(1'b0, 60);
        `CHK(n, 60, "start at reserved rate")
        wr(ADDR_MAIN_CTRL, 8'h00);
        wr(ADDR_SEC_CTRL, 8'h01);
        wait_ev(1'b0, 60);
        `CHK(n, 60, "start in power-down")
        wr(ADDR_SEC_CTRL, 8'h00);
        $display("test single finished");
        for (int r = 1; r <= 4; r++) begin
            wr(ADDR_MAIN_CTRL, {1'b1, 3'(r), 4'h0});
            repeat (3) wait_ev(1'b0, 100);
            `CHK(n, PER[r], "update period")
        end
        press_val = 24'hA1B2C3;
        wr(ADDR_MAIN_CTRL, 8'hC4);
        shot();
        rd(ADDR_PRESS_LOW, 8'hC3);
        press_val = 24'h5D6E7F;
        repeat (30) @(posedge core_clk);
        rd(ADDR_PRESS_HIGH, 8'hA1);
        repeat (15) @(posedge core_clk);
        rd(ADDR_PRESS_LOW, 8'h7F);
        wr(ADDR_MAIN_CTRL, 8'hC0);
        press_val = 24'h102030;
        repeat (30) @(posedge core_clk);
        rd(ADDR_PRESS_LOW, 8'h30);
        press_val = 24'h405060;
        repeat (30) @(posedge core_clk);
        rd(ADDR_PRESS_HIGH, 8'h40);
        rd(ADDR_TEMP_HIGH, 8'h50);
        $display("test periodic finished");
        wr(ADDR_MAIN_CTRL, 8'h80);
        repeat (20) @(posedge core_clk);
        press_val = 24'h0ABCDE;
        wr(ADDR_SEC_CTRL, 8'h01);
        shot();
        wr(ADDR_SEC_CTRL, 8'h02);
        rd24(ADDR_REF_LOW, 24'h0ABCDE);
        press_val = 24'h1F0000;
        wr(ADDR_SEC_CTRL, 8'h03);
        shot();
        rd24(ADDR_PRESS_LOW, 24'h1F0000 - 24'h0ABCDE);
        wr(ADDR_OFS_LOW, 8'h11);
        wr(ADDR_OFS_HIGH, 8'h22);
        `CHK(press_offset, 16'h2211, "offset write")
        wr(ADDR_MAIN_CTRL, 8'h82);
        `CHK(press_offset, 16'h0000, "offset clear")
        rd24(ADDR_REF_LOW, 24'h000000);
        rd(ADDR_MAIN_CTRL, 8'h80);
        `CHK(diff_pressure, 24'h012345 - 24'hF23456, "diff held")
        $display("test autozero finished");
        conclude();
    end
endmodule
